// File: include/rxq_pkg.sv
// constants, register map and types for the receive queue block
package rxq_pkg;
  // register byte offsets on the wishbone slave
  localparam logic [7:0] ADR_OPMODE   = 8'h00;
  localparam logic [7:0] ADR_QCTRL    = 8'h04;
  localparam logic [7:0] ADR_FILTER   = 8'h08;
  localparam logic [7:0] ADR_CHSEL    = 8'h0C;
  localparam logic [7:0] ADR_INT_STAT = 8'h10;
  localparam logic [7:0] ADR_INT_MASK = 8'h14;
  localparam logic [7:0] ADR_DMA_STAT = 8'h18;
  // field positions
  localparam int OPM_SF_BIT     = 5;  // store_forward_select
  localparam int OPM_THR_LSB    = 0;  // receive threshold control, two bits
  localparam int QC_FARB_BIT    = 3;  // frame_arbitration_enable
  localparam int FLT_RALL_BIT   = 0;  // receive all
  localparam int FLT_PROM_BIT   = 1;  // promiscuous
  localparam int FLT_SPLIT_BIT  = 2;  // header_split_option
  localparam int DS_FATAL_BIT   = 0;  // fatal bus error flag
  localparam int DS_ECH_LSB     = 4;  // faulting channel
  localparam int DS_GNT_LSB     = 8;  // latest granted channel
  localparam int DS_LVL_LSB     = 16; // fifo fill level
  // interrupt status bits
  localparam int IRQ_HDR        = 0;
  localparam int IRQ_DROP       = 1;
  localparam int IRQ_FATAL      = 2;
  localparam int IRQ_DESC       = 3;
  localparam int IRQ_W          = 4;
  // header status word layout
  localparam int HS_SIZE_LSB    = 0;  // eight bits of header size
  localparam int HS_MATCH_BIT   = 8;
  localparam int HS_CHAN_LSB    = 12; // two bits of channel
  // sizes
  localparam int RX_CHANNEL_COUNT = 4;
  localparam int CH_W             = 2;
  localparam int FIFO_DEPTH       = 64;
  localparam int PTR_W            = 6;
  localparam int HQ_DEPTH         = 4;
  localparam int HQ_W             = 2;
  localparam int BURST_LEN        = 8;
  localparam logic [2:0] BURST_LAST = 3'h7;
  localparam int THR_STEP_LOG2    = 3;  // threshold step of eight words
  // reset values
  localparam logic [7:0] OPMODE_RST = 8'h00;
  localparam logic [7:0] QCTRL_RST  = 8'h00;
  localparam logic [7:0] FILTER_RST = 8'h00;
  localparam logic [7:0] CHSEL_RST  = 8'h00;
  // read side states
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_XFER = 2'b01,
    RD_GAP  = 2'b10,
    RD_STAT = 2'b11
  } rd_state_t;
endpackage

// File: logic/rx_queue.sv
// receive queue controller with header status, fifo, dma hand-off and bus error status
`timescale 1ns/10ps
// What this block does
// - build header status word for every packet
// - status holds header size and channel
// - channel comes from matching address register
// - issue status when address compare finishes
// - store status before forwarding any data
// - drop mismatches unless receive-all or promiscuous
// - cut-through reads out after threshold crossed
// - store-forward bit 5 zero means cut-through
// - queue control bit 3 enables frame arbitration
// - descriptor status stays correct after fifo drains
// - near end, report latest granted channel
// - bus error reports owner of failing burst
module rx_queue import rxq_pkg::*; (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // header parse results from the mac receiver
  input  wire logic                 da_done_i,
  input  wire logic                 da_match_i,
  input  wire logic [1:0]           da_match_idx_i,
  input  wire logic [7:0]           hdr_size_i,
  output logic                      hdr_valid_o,
  output logic      [15:0]          hdr_status_o,
  // packet data from the mac receiver
  input  wire logic                 rx_valid_i,
  input  wire logic [31:0]          rx_data_i,
  input  wire logic                 rx_eop_i,
  output logic                      rx_ready_o,
  // data towards the receive dma channels
  output logic                      dma_valid_o,
  output logic      [31:0]          dma_data_o,
  output logic                      dma_last_o,
  output logic      [CH_W-1:0]      dma_chan_o,
  input  wire logic                 dma_ready_i,
  output logic      [CH_W-1:0]      latest_grant_o,
  // descriptor status write-back
  output logic                      desc_valid_o,
  output logic      [31:0]          desc_status_o,
  // system bus error for the burst in flight
  input  wire logic                 bus_err_i,
  output logic                      irq_o
);

  // all state in one record
  typedef struct packed {
    logic [FIFO_DEPTH-1:0][32:0] mem;      // data plus end marker
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [PTR_W:0]              count;    // words held
    logic [PTR_W:0]              eop_pend; // whole packets held
    logic [HQ_DEPTH-1:0][CH_W-1:0] hq;     // stored header channels
    logic [HQ_W-1:0]             hq_wr;
    logic [HQ_W-1:0]             hq_rd;
    logic [HQ_W:0]               hq_cnt;
    logic                        hdr_seen; // header decided for packet in flight
    logic                        drop;     // packet in flight is discarded
    logic                        hdr_valid;
    logic [15:0]                 hdr_status;
    rd_state_t                   st;
    logic [CH_W-1:0]             cur_chan;
    logic [2:0]                  beat;
    logic [15:0]                 len;
    logic [CH_W-1:0]             owner;    // channel of the burst in flight
    logic [CH_W-1:0]             grant;
    logic                        desc_valid;
    logic [31:0]                 desc_status;
    logic                        fatal;
    logic [CH_W-1:0]             err_chan;
    logic [7:0]                  opmode;
    logic [7:0]                  qctrl;
    logic [7:0]                  filter;
    logic [7:0]                  chsel;
    logic [IRQ_W-1:0]            int_stat;
    logic [IRQ_W-1:0]            int_mask;
    logic                        ack;
    logic [31:0]                 rdat;
  } state_t;

  state_t s_q;   // registered state
  state_t s_d;   // next state

  // decoded controls
  logic                 sf_mode;      // store and forward selected
  logic                 frame_arb;    // frame based arbitration
  logic [PTR_W:0]       threshold;    // cut-through threshold in words
  logic                 wb_req;       // new bus request this cycle
  logic                 wr_en;        // word written into fifo
  logic                 rd_en;        // word taken by dma
  logic                 full;
  logic                 pass_all;     // receive-all or promiscuous
  logic [CH_W-1:0]      sel_chan;     // channel of matching address register
  logic                 start_ok;     // head packet may start
  logic [31:0]          rd_mux;
  logic [31:0]          wmask;

  assign sf_mode   = s_q.opmode[OPM_SF_BIT];
  assign frame_arb = s_q.qctrl[QC_FARB_BIT];
  assign threshold = (PTR_W+1)'({s_q.opmode[OPM_THR_LSB +: 2], 3'h0}) +
                     (PTR_W+1)'(1 << THR_STEP_LOG2);
  assign pass_all  = s_q.filter[FLT_RALL_BIT] | s_q.filter[FLT_PROM_BIT];
  assign sel_chan  = s_q.chsel[{da_match_idx_i, 1'b0} +: CH_W];
  assign full      = (s_q.count == (PTR_W+1)'(FIFO_DEPTH));
  assign wb_req    = wb_cyc_i & wb_stb_i & ~s_q.ack;
  // stall data until its header is decided, so nothing overtakes the status
  assign rx_ready_o = s_q.hdr_seen & (s_q.drop | ~full);
  assign wr_en     = rx_valid_i & rx_ready_o & ~s_q.drop;
  // dma sees data only while a packet is granted and data is present
  assign dma_valid_o = (s_q.st == RD_XFER) & (s_q.count != '0);
  assign rd_en     = dma_valid_o & dma_ready_i;
  // cut-through starts on the threshold, store-forward waits for a whole packet
  assign start_ok  = (s_q.hq_cnt != '0) &&
                     ((s_q.eop_pend != '0) || (!sf_mode && s_q.count >= threshold));

  // byte lane mask from wishbone select
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{wb_sel_i[i]}};
    end
  end

  // register read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      ADR_OPMODE:   rd_mux[7:0] = s_q.opmode;
      ADR_QCTRL:    rd_mux[7:0] = s_q.qctrl;
      ADR_FILTER:   rd_mux[7:0] = s_q.filter;
      ADR_CHSEL:    rd_mux[7:0] = s_q.chsel;
      ADR_INT_STAT: rd_mux[IRQ_W-1:0] = s_q.int_stat;
      ADR_INT_MASK: rd_mux[IRQ_W-1:0] = s_q.int_mask;
      ADR_DMA_STAT: begin
        rd_mux[DS_FATAL_BIT]             = s_q.fatal;
        rd_mux[DS_ECH_LSB +: CH_W]       = s_q.err_chan;
        rd_mux[DS_GNT_LSB +: CH_W]       = s_q.grant;
        rd_mux[DS_LVL_LSB +: PTR_W+1]    = s_q.count;
      end
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // next state
  always_comb begin
    logic [IRQ_W-1:0] ev;
    logic             do_drop;
    ev      = '0;
    do_drop = 1'b0;
    s_d     = s_q;
    s_d.hdr_valid  = 1'b0;
    s_d.desc_valid = 1'b0;

    // wishbone: answer one cycle after the request, ack lasts one cycle
    s_d.ack = wb_req;
    if (wb_req) begin
      s_d.rdat = rd_mux;
      if (wb_we_i) begin
        case (wb_adr_i)
          ADR_OPMODE:   s_d.opmode = (s_q.opmode & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
          ADR_QCTRL:    s_d.qctrl  = (s_q.qctrl & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
          ADR_FILTER:   s_d.filter = (s_q.filter & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
          ADR_CHSEL:    s_d.chsel  = (s_q.chsel & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
          ADR_INT_MASK: begin
            if (wb_sel_i[0]) begin
              s_d.int_mask = wb_dat_i[IRQ_W-1:0];
            end
          end
          ADR_DMA_STAT: begin
            // write one to the flag clears the fatal report
            if (wb_sel_i[0] && wb_dat_i[DS_FATAL_BIT]) begin
              s_d.fatal = 1'b0;
            end
          end
          default: ;                                             // ignored, still acked
        endcase
      end else if (wb_adr_i == ADR_INT_STAT) begin
        s_d.int_stat = '0;                                       // read clears
      end
    end

    // end of the packet in flight clears its decision first, so the header
    // of the next packet landing in the same cycle is not lost
    if (rx_valid_i && rx_ready_o && rx_eop_i) begin
      s_d.hdr_seen = 1'b0;
      s_d.drop = 1'b0;
    end

    // header decision when address compare finishes, matched or not
    if (da_done_i) begin
      s_d.hdr_valid = 1'b1;
      s_d.hdr_status = '0;
      s_d.hdr_status[HS_MATCH_BIT] = da_match_i;
      if (s_q.filter[FLT_SPLIT_BIT]) begin
        s_d.hdr_status[HS_SIZE_LSB +: 8] = hdr_size_i;
      end
      if (RX_CHANNEL_COUNT > 1 && da_match_i) begin
        s_d.hdr_status[HS_CHAN_LSB +: CH_W] = sel_chan;
      end
      ev[IRQ_HDR] = 1'b1;
      s_d.hdr_seen = 1'b1;
      do_drop = ~da_match_i & ~pass_all;
      s_d.drop = do_drop;
      ev[IRQ_DROP] = do_drop;
      if (!do_drop) begin
        // keep the channel so forwarding can follow the status
        s_d.hq[s_q.hq_wr] = da_match_i ? sel_chan : '0;
        s_d.hq_wr = s_q.hq_wr + 1'b1;
      end
    end

    // writes into the fifo; end marker travels with the last word
    if (wr_en) begin
      s_d.mem[s_q.wr_ptr] = {rx_eop_i, rx_data_i};
      s_d.wr_ptr = s_q.wr_ptr + 1'b1;
    end

    // read side arbitration and hand-off
    case (s_q.st)
      RD_IDLE: begin
        if (start_ok) begin
          s_d.st       = RD_XFER;
          s_d.cur_chan = s_q.hq[s_q.hq_rd];
          s_d.grant    = s_q.hq[s_q.hq_rd];
          s_d.hq_rd    = s_q.hq_rd + 1'b1;
          s_d.beat     = '0;
          s_d.len      = '0;
        end
      end
      RD_XFER: begin
        if (rd_en) begin
          s_d.rd_ptr = s_q.rd_ptr + 1'b1;
          s_d.len    = s_q.len + 16'h0001;
          s_d.beat   = s_q.beat + 3'h1;
          s_d.owner  = s_q.cur_chan;
          if (s_q.mem[s_q.rd_ptr][32]) begin
            // last word: latch status now so a draining fifo cannot spoil it
            s_d.desc_status = {s_q.cur_chan, 14'h0000, s_q.len + 16'h0001};
            s_d.st = RD_STAT;
            if (s_q.hq_cnt != '0) begin
              s_d.grant = s_q.hq[s_q.hq_rd];
            end
          end else if (s_q.beat == BURST_LAST && !frame_arb) begin
            // without frame arbitration each burst of eight ends in a one-cycle gap on the same grant
            s_d.st = RD_GAP;
          end
        end
      end
      RD_GAP:  s_d.st = RD_XFER;
      RD_STAT: begin
        s_d.desc_valid = 1'b1;
        ev[IRQ_DESC]   = 1'b1;
        s_d.st         = RD_IDLE;
      end
      default: s_d.st = RD_IDLE;
    endcase

    // occupancy counters
    s_d.count = s_q.count + (PTR_W+1)'(wr_en) - (PTR_W+1)'(rd_en);
    s_d.eop_pend = s_q.eop_pend + (PTR_W+1)'(wr_en & rx_eop_i)
                 - (PTR_W+1)'(rd_en & s_q.mem[s_q.rd_ptr][32]);
    s_d.hq_cnt = s_q.hq_cnt + (HQ_W+1)'(da_done_i & ~do_drop)
               - (HQ_W+1)'((s_q.st == RD_IDLE) & start_ok);

    // bus error: blame the burst owner, never the newer grant
    if (bus_err_i) begin
      s_d.fatal    = 1'b1;
      s_d.err_chan = s_q.owner;
      ev[IRQ_FATAL] = 1'b1;
    end

    // sticky events: a new event beats a clearing read
    s_d.int_stat = s_d.int_stat | ev;
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q        <= '0;
      s_q.st     <= RD_IDLE;
      s_q.opmode <= OPMODE_RST;
      s_q.qctrl  <= QCTRL_RST;
      s_q.filter <= FILTER_RST;
      s_q.chsel  <= CHSEL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign wb_ack_o       = s_q.ack;
  assign wb_dat_o       = s_q.rdat;
  assign hdr_valid_o    = s_q.hdr_valid;
  assign hdr_status_o   = s_q.hdr_status;
  assign dma_data_o     = s_q.mem[s_q.rd_ptr][31:0];
  assign dma_last_o     = s_q.mem[s_q.rd_ptr][32];
  assign dma_chan_o     = s_q.cur_chan;
  assign latest_grant_o = s_q.grant;
  assign desc_valid_o   = s_q.desc_valid;
  assign desc_status_o  = s_q.desc_status;
  assign irq_o          = |(s_q.int_stat & s_q.int_mask);

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_last_taken;
    dma_valid_o && dma_ready_i && dma_last_o;
  endsequence

  AST_HDR_ON_COMPARE: assert property (da_done_i |=> hdr_valid_o)
    else $error("header status not issued after compare");
  AST_HDR_CHANNEL: assert property (da_done_i && da_match_i
      |=> hdr_status_o[HS_CHAN_LSB +: CH_W] == $past(sel_chan))
    else $error("header channel not from matching register");
  AST_HDR_SIZE: assert property (da_done_i && s_q.filter[FLT_SPLIT_BIT]
      |=> hdr_status_o[7:0] == $past(hdr_size_i))
    else $error("header size missing");
  AST_NO_DATA_EARLY: assert property (s_q.st == RD_IDLE && s_q.hq_cnt == '0
      |=> s_q.st == RD_IDLE && !dma_valid_o)
    else $error("data forwarded before header stored");
  AST_DROP: assert property (da_done_i && !da_match_i && !pass_all
      |=> s_q.drop && s_q.hq_wr == $past(s_q.hq_wr))
    else $error("mismatched packet not dropped");
  AST_CUT_THROUGH: assert property (s_q.st == RD_IDLE && s_q.hq_cnt != '0 && !sf_mode
      && s_q.count >= threshold |=> s_q.st == RD_XFER)
    else $error("cut-through start missed");
  AST_SF_WAIT: assert property (s_q.st == RD_IDLE && sf_mode && s_q.eop_pend == '0
      |=> s_q.st == RD_IDLE)
    else $error("store-forward started before packet end");
  AST_BURST_GAP: assert property (rd_en && s_q.beat == BURST_LAST && !dma_last_o
      && !frame_arb |=> !dma_valid_o ##1 s_q.st == RD_XFER)
    else $error("burst re-arbitration gap missing");
  AST_DESC: assert property (seq_last_taken |=> ##1 desc_valid_o
      && desc_status_o[15:0] == $past(s_q.len, 2) + 16'h0001)
    else $error("descriptor status wrong");
  AST_GRANT: assert property (seq_last_taken ##0 s_q.hq_cnt != '0
      |=> latest_grant_o == $past(s_q.hq[s_q.hq_rd]))
    else $error("latest grant not reported");
  AST_ERR_OWNER: assert property (bus_err_i |=> s_q.fatal
      && s_q.err_chan == $past(s_q.owner) ##1 s_q.fatal)
    else $error("bus error channel or flag wrong");

endmodule

// File: sim/mac_rx_model.sv
// behavioural mac receiver and dma sink facing the receive queue
`timescale 1ns/10ps
module mac_rx_model (
  // clock, reset and bench control
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        go_i,
  input  wire logic        match_i,
  input  wire logic [1:0]  idx_i,
  input  wire logic [7:0]  size_i,
  input  wire logic [7:0]  len_i,
  input  wire logic        stall_i,
  // receiver side of the queue
  input  wire logic        rx_ready_i,
  output logic             da_done_o,
  output logic             da_match_o,
  output logic [1:0]       da_match_idx_o,
  output logic [7:0]       hdr_size_o,
  output logic             rx_valid_o,
  output logic [31:0]      rx_data_o,
  output logic             rx_eop_o,
  // dma sink and progress
  output logic             dma_ready_o,
  output logic             busy_o,
  output logic [7:0]       sent_o
);
  logic [7:0] tog_q; // free count that paces a stalling sink

  // a stalling sink accepts only every other cycle
  assign dma_ready_o = !stall_i || tog_q[0];

  // header first, then words held until taken
  always_ff @(posedge clk_i) begin
    da_done_o <= 1'b0;
    if (rst_i) begin
      busy_o     <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_eop_o   <= 1'b0;
      rx_data_o  <= 32'h0;
      sent_o     <= 8'h0;
      tog_q      <= 8'h0;
    end else begin
      tog_q <= tog_q + 8'h1;
      if (go_i && !busy_o) begin
        // compare result always precedes the packet words
        da_done_o      <= 1'b1;
        da_match_o     <= match_i;
        da_match_idx_o <= idx_i;
        hdr_size_o     <= size_i;
        busy_o         <= 1'b1;
        sent_o         <= 8'h0;
      end else if (busy_o && !rx_valid_o) begin
        rx_valid_o <= 1'b1;
        rx_data_o  <= {24'hA5A500, sent_o};
        rx_eop_o   <= (sent_o == len_i - 8'h1);
      end else if (busy_o && rx_ready_i) begin
        sent_o <= sent_o + 8'h1;
        if (rx_eop_o) begin
          // released lines show garbage, not the last word
          rx_valid_o     <= 1'b0;
          rx_eop_o       <= 1'b0;
          rx_data_o      <= ~rx_data_o;
          da_match_o     <= ~da_match_o;
          da_match_idx_o <= ~da_match_idx_o;
          busy_o         <= 1'b0;
        end else begin
          rx_data_o <= {24'hA5A500, sent_o + 8'h1};
          rx_eop_o  <= (sent_o + 8'h1 == len_i - 8'h1);
        end
      end
    end
  end
endmodule

// File: sim/tb_top.sv
// self-checking bench for the receive queue
`timescale 1ns/10ps
module tb_top;
  import rxq_pkg::*;
  typedef struct packed {logic [7:0] adr; logic [31:0] wd; logic [31:0] ex;} row_t;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, go, match, stall, bus_err_i;
  logic [7:0] wb_adr, idx_sz, size, len, sent, sent_at, beats, err_at;
  logic [1:0] idx, exp_ch;
  logic [31:0] wb_wdat, wb_dat_o, rx_data, dma_data_o, desc_status_o, rd;
  logic [15:0] hdr_status_o, exp_hs;
  logic wb_ack_o, da_done, da_match, hdr_valid_o, rx_valid, rx_eop, rx_ready_o;
  logic dma_valid_o, dma_last_o, dma_ready, desc_valid_o, irq_o, busy, dd_q, seen, desc_seen;
  logic split;
  logic [1:0] da_idx, dma_chan_o, latest_grant_o;
  int fails, checks, cycles;
  // register rows: reset value 0, then written value read back; the unmapped row 8'h20 reads back zero
  row_t rows[6] = '{'{ADR_OPMODE, 32'h20, 32'h20}, '{ADR_QCTRL, 32'h08, 32'h08},
                    '{ADR_FILTER, 32'h04, 32'h04}, '{ADR_CHSEL, 32'h1B, 32'h1B},
                    '{ADR_INT_MASK, 32'h04, 32'h04}, '{8'h20, 32'hFF, 32'h00}};

  rx_queue i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .da_done_i(da_done), .da_match_i(da_match),
    .da_match_idx_i(da_idx), .hdr_size_i(idx_sz), .hdr_valid_o(hdr_valid_o),
    .hdr_status_o(hdr_status_o), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
    .rx_eop_i(rx_eop), .rx_ready_o(rx_ready_o), .dma_valid_o(dma_valid_o),
    .dma_data_o(dma_data_o), .dma_last_o(dma_last_o), .dma_chan_o(dma_chan_o),
    .dma_ready_i(dma_ready), .latest_grant_o(latest_grant_o), .desc_valid_o(desc_valid_o),
    .desc_status_o(desc_status_o), .bus_err_i(bus_err_i), .irq_o(irq_o));

  mac_rx_model i_mac (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .match_i(match), .idx_i(idx),
    .size_i(size), .len_i(len), .stall_i(stall), .rx_ready_i(rx_ready_o), .da_done_o(da_done),
    .da_match_o(da_match), .da_match_idx_o(da_idx), .hdr_size_o(idx_sz), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data), .rx_eop_o(rx_eop), .dma_ready_o(dma_ready), .busy_o(busy),
    .sent_o(sent));

  // 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // compare with case equality so unknowns never match
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
    checks++;
    if (got !== ex) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // one classic wishbone cycle, held until ack is sampled
  task automatic wb_rw(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    // only the bench timeout ends a wait for the answer
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  // one packet through the model; expectations set beforehand
  task automatic send(input logic m, input logic [1:0] ix, input logic [7:0] sz, ln,
                      input logic st, input logic [7:0] ea, input logic wd);
    exp_ch = m ? 2'(8'h1B >> (2 * ix)) : 2'h0;
    exp_hs = {2'h0, exp_ch, 3'h0, m, split ? sz : 8'h0};
    beats = 0;
    seen = 0;
    desc_seen = 0;
    err_at <= ea;
    stall <= st;
    len <= ln;
    match <= m;
    idx <= ix;
    size <= sz;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    do begin
      @(posedge clk_i);
    end while (busy || (wd && !desc_seen));
    repeat (30) @(posedge clk_i);
  endtask

  // watchers on header, dma beats, descriptor and run time
  always @(posedge clk_i) begin
    bus_err_i <= 1'b0;
    dd_q <= da_done;
    cycles++;
    if (dd_q === 1'b1) begin
      chk("hdr_valid", hdr_valid_o, 32'h1);
      chk("hdr_status", hdr_status_o, exp_hs);
    end
    if (dma_valid_o === 1'b1 && !seen) begin
      seen = 1;
      sent_at = sent;
    end
    if (dma_valid_o === 1'b1 && dma_ready === 1'b1) begin
      beats++;
      chk("dma_data", dma_data_o, {24'hA5A500, beats - 8'h1});
      chk("dma_chan", dma_chan_o, exp_ch);
      chk("grant", latest_grant_o, exp_ch);
      if (beats == err_at) bus_err_i <= 1'b1;
      if (dma_last_o === 1'b1) chk("beats", beats, len);
    end
    if (desc_valid_o === 1'b1) begin
      desc_seen = 1;
      chk("desc_chan", desc_status_o[31:30], exp_ch);
      chk("desc_len", desc_status_o[15:0], len);
    end
    if (cycles == 6000) begin
      fails++;
      close_out();
    end
  end

  initial begin
    {rst_i, wb_cyc, wb_stb, wb_we, go, match, stall, bus_err_i, dd_q} = 9'h100;
    {wb_adr, wb_wdat, idx, size, len, err_at, beats} = '0;
    cycles = 0;
    split = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("irq_rst", irq_o, 32'h0);
    foreach (rows[i]) begin
      wb_rw(1'b0, rows[i].adr, 32'h0);
      chk("reg_reset", rd, 32'h0);
      wb_rw(1'b1, rows[i].adr, rows[i].wd);
      wb_rw(1'b0, rows[i].adr, 32'h0);
      chk("reg_readback", rd, rows[i].ex);
    end
    // store and forward, matched, sink stalling
    send(1'b1, 2'h1, 8'h2A, 8'd10, 1'b1, 8'h0, 1'b1);
    chk("store_fwd", sent_at, 32'd10);
    chk("irq_masked", irq_o, 32'h0);
    wb_rw(1'b0, ADR_INT_STAT, 32'h0);
    chk("int_stat", rd[7:0], 32'h09);
    // unmatched with plain filtering is dropped
    send(1'b0, 2'h2, 8'h16, 8'd6, 1'b0, 8'h0, 1'b0);
    chk("drop_beats", beats, 32'h0);
    wb_rw(1'b0, ADR_INT_STAT, 32'h0);
    chk("int_drop", rd[7:0], 32'h03);
    // unmatched, promiscuous, cut-through from eight words
    wb_rw(1'b1, ADR_OPMODE, 32'h00);
    wb_rw(1'b1, ADR_FILTER, 32'h02);
    // frame arbitration off here, so bursts of eight get their gap
    wb_rw(1'b1, ADR_QCTRL, 32'h00);
    split = 1'b0;
    send(1'b0, 2'h2, 8'h11, 8'd20, 1'b0, 8'h0, 1'b1);
    chk("cut_through", sent_at >= 8 && sent_at < 20, 32'h1);
    // frame arbitration, bus error in mid burst
    wb_rw(1'b1, ADR_QCTRL, 32'h08);
    send(1'b1, 2'h0, 8'h30, 8'd12, 1'b1, 8'd3, 1'b0);
    wb_rw(1'b0, ADR_DMA_STAT, 32'h0);
    chk("err_status", rd & 32'h331, 32'h331);
    chk("irq_fatal", irq_o, 32'h1);
    wb_rw(1'b0, ADR_INT_STAT, 32'h0);
    chk("int_fatal", rd & 32'h4, 32'h4);
    chk("irq_clear", irq_o, 32'h0);
    wb_rw(1'b1, ADR_DMA_STAT, 32'h1);
    wb_rw(1'b0, ADR_DMA_STAT, 32'h0);
    chk("fatal_clear", rd & 32'h1, 32'h0);
    // reset in mid-run brings the queue control back to its default
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_rw(1'b0, ADR_QCTRL, 32'h0);
    chk("qctrl_rerst", rd, 32'h0);
    chk("irq_rerst", irq_o, 32'h0);
    close_out();
  end
endmodule
